// ---- verilog/dsf_map.vh ----
`ifndef DSF_MAP_VH
`define DSF_MAP_VH

// Register byte offsets
`define DSF_ZERO_THR_OFS    8'h00
`define DSF_DEV_LIM_OFS     8'h04
`define DSF_OL_THR_OFS      8'h08
`define DSF_VLOSS_THR_OFS   8'h0c
`define DSF_ILOSS_THR_OFS   8'h10
`define DSF_PID_LO_OFS      8'h14
`define DSF_PID_HI_OFS      8'h18
`define DSF_WDOG_PER_OFS    8'h1c
`define DSF_LOGIC_CFG_OFS   8'h20
`define DSF_TERM_SEL_OFS    8'h24
`define DSF_FLAGS_OFS       8'h28
`define DSF_IRQ_STAT_OFS    8'h2c
`define DSF_IRQ_MASK_OFS    8'h30

// Reset values
`define DSF_THR_RST         16'h0000
`define DSF_WDOG_PER_RST    24'h000000
`define DSF_LOGIC_CFG_RST   30'h00000000
`define DSF_TERM_SEL_RST    16'h0000
`define DSF_MASK_RST        14'h0000

// Flag vector positions
`define DSF_F_ZERO          0
`define DSF_F_DEV           1
`define DSF_F_POSD          2
`define DSF_F_OVF           3
`define DSF_F_ATF           4
`define DSF_F_OVL           5
`define DSF_F_VLOSS         6
`define DSF_F_ILOSS         7
`define DSF_F_PIDS          8
`define DSF_F_NETL          9
`define DSF_F_LOGA          10
`define DSF_F_LOGB          11
`define DSF_F_LOGC          12
`define DSF_F_CAPW          13
`define DSF_NFLAGS          14

// Logic config field layout, one 10-bit slice per user output
`define DSF_LCFG_W          10
`define DSF_LCFG_A_LSB      0
`define DSF_LCFG_B_LSB      4
`define DSF_LCFG_OP_LSB     8
`define DSF_OP_AND          2'h0
`define DSF_OP_OR           2'h1
`define DSF_OP_XOR          2'h2

// Terminal option codes
`define DSF_CODE_ZERO       8'h15
`define DSF_CODE_DEV        8'h16
`define DSF_CODE_POSD       8'h17
`define DSF_CODE_OVF        8'h18
`define DSF_CODE_ATF        8'h19
`define DSF_CODE_OVL        8'h1a
`define DSF_CODE_VLOSS      8'h1b
`define DSF_CODE_ILOSS      8'h1c
`define DSF_CODE_PIDS       8'h1f
`define DSF_CODE_NETL       8'h20
`define DSF_CODE_LOGA       8'h21
`define DSF_CODE_LOGB       8'h22
`define DSF_CODE_LOGC       8'h23
`define DSF_CODE_CAPW       8'h27

`endif

// ---- verilog/dsf_logic_op.v ----
`timescale 1ns/100ps
`include "dsf_map.vh"
module dsf_logic_op (
   input  wire [15:0] src_v,    // Selectable source flags
   input  wire [9:0]  cfg,      // Op and source selects
   output reg         result    // Boolean result
);
   reg a;
   reg b;
   always @* begin
      a = src_v[cfg[`DSF_LCFG_A_LSB +: 4]];
      b = src_v[cfg[`DSF_LCFG_B_LSB +: 4]];
      case (cfg[`DSF_LCFG_OP_LSB +: 2])
         `DSF_OP_AND: result = a & b;
         `DSF_OP_OR:  result = a | b;
         `DSF_OP_XOR: result = a ^ b;
         default:     result = 1'b0;
      endcase
   end
endmodule

// ---- verilog/dsf_flags.v ----
`timescale 1ns/100ps
`include "dsf_map.vh"
module dsf_flags #(
   parameter DW    = 16,                  // Measurement width
   parameter NTERM = 2                    // Output terminals
) (
   input  wire             CLK,              // System clock
   input  wire             RESETN,           // Async reset, active low
   input  wire [7:0]       AVS_ADDRESS,      // Byte address
   input  wire             AVS_READ,         // Read request
   input  wire             AVS_WRITE,        // Write request
   input  wire [3:0]       AVS_BYTEENABLE,   // Byte lanes
   input  wire [31:0]      AVS_WRITEDATA,    // Write data
   output reg  [31:0]      AVS_READDATA,     // Read data
   output reg              AVS_WAITREQUEST,  // Stall
   input  wire [DW-1:0]    OUT_FREQ,         // Output frequency
   input  wire [DW-1:0]    SET_FREQ,         // Set frequency
   input  wire [DW-1:0]    SPEED_CMD,        // Commanded speed
   input  wire [DW-1:0]    SPEED_ACT,        // Actual speed
   input  wire [DW-1:0]    OUT_CURRENT,      // Output current
   input  wire [DW-1:0]    AIN_VOLT,         // Voltage input reading
   input  wire [DW-1:0]    AIN_CURR,         // Current input reading
   input  wire [DW-1:0]    PID_PV,           // Process variable
   input  wire             RUN_MODE,         // Drive running
   input  wire             POS_DONE,         // Positioning complete
   input  wire             COMM_ACT,         // Communication activity pulse
   input  wire             CAP_EXPIRED,      // Capacitor lifetime expired
   output reg  [NTERM-1:0] TERM_OUT,         // Output terminals
   output reg              IRQ               // Interrupt, level
);
   localparam NF = `DSF_NFLAGS;

   // Registered measurements
   reg [DW-1:0] ofreq_q, sfreq_q, scmd_q, sact_q, cur_q, ainv_q, aini_q, pv_q;
   reg          run_q, pos_q, comm_q, cap_q, run_prev_q;

   // Configuration
   reg [DW-1:0]      zero_thr_q, dev_lim_q, ol_thr_q, vloss_thr_q, iloss_thr_q;
   reg [DW-1:0]      pid_lo_q, pid_hi_q;
   reg [23:0]        wdog_per_q;
   reg [29:0]        lcfg_q;
   reg [8*NTERM-1:0] tsel_q;
   reg [NF-1:0]      mask_q;

   // State
   reg [NF-1:0] flags_q;
   reg [NF-1:0] flags_prev_q;
   reg [NF-1:0] stat_q;
   reg [NF-1:0] stat_d;
   reg          pid_stage_q;
   reg          net_loss_q;
   reg [23:0]   wdog_cnt_q;

   wire         req     = AVS_READ | AVS_WRITE;
   wire         wr_fire = AVS_WRITE & ~AVS_WAITREQUEST;
   wire [31:0]  bmask   = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                           {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

   // Write data under enabled lanes, and lanes kept
   wire [31:0]  wr_new  = AVS_WRITEDATA & bmask;
   wire [31:0]  wr_keep = ~bmask;

   function sel_flag;
      input [7:0]    code;
      input [NF-1:0] f;
      begin
         case (code)
            `DSF_CODE_ZERO:  sel_flag = f[`DSF_F_ZERO];
            `DSF_CODE_DEV:   sel_flag = f[`DSF_F_DEV];
            `DSF_CODE_POSD:  sel_flag = f[`DSF_F_POSD];
            `DSF_CODE_OVF:   sel_flag = f[`DSF_F_OVF];
            `DSF_CODE_ATF:   sel_flag = f[`DSF_F_ATF];
            `DSF_CODE_OVL:   sel_flag = f[`DSF_F_OVL];
            `DSF_CODE_VLOSS: sel_flag = f[`DSF_F_VLOSS];
            `DSF_CODE_ILOSS: sel_flag = f[`DSF_F_ILOSS];
            `DSF_CODE_PIDS:  sel_flag = f[`DSF_F_PIDS];
            `DSF_CODE_NETL:  sel_flag = f[`DSF_F_NETL];
            `DSF_CODE_LOGA:  sel_flag = f[`DSF_F_LOGA];
            `DSF_CODE_LOGB:  sel_flag = f[`DSF_F_LOGB];
            `DSF_CODE_LOGC:  sel_flag = f[`DSF_F_LOGC];
            `DSF_CODE_CAPW:  sel_flag = f[`DSF_F_CAPW];
            default:         sel_flag = 1'b0;
         endcase
      end
   endfunction

   // Measurement capture
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ofreq_q    <= {DW{1'b0}};
         sfreq_q    <= {DW{1'b0}};
         scmd_q     <= {DW{1'b0}};
         sact_q     <= {DW{1'b0}};
         cur_q      <= {DW{1'b0}};
         ainv_q     <= {DW{1'b0}};
         aini_q     <= {DW{1'b0}};
         pv_q       <= {DW{1'b0}};
         run_q      <= 1'b0;
         pos_q      <= 1'b0;
         comm_q     <= 1'b0;
         cap_q      <= 1'b0;
         run_prev_q <= 1'b0;
      end else begin
         ofreq_q    <= OUT_FREQ;
         sfreq_q    <= SET_FREQ;
         scmd_q     <= SPEED_CMD;
         sact_q     <= SPEED_ACT;
         cur_q      <= OUT_CURRENT;
         ainv_q     <= AIN_VOLT;
         aini_q     <= AIN_CURR;
         pv_q       <= PID_PV;
         run_q      <= RUN_MODE;
         pos_q      <= POS_DONE;
         comm_q     <= COMM_ACT;
         cap_q      <= CAP_EXPIRED;
         run_prev_q <= run_q;
      end
   end

   wire [DW-1:0] spd_err = (scmd_q >= sact_q) ? (scmd_q - sact_q) : (sact_q - scmd_q);
   wire          out_on  = (ofreq_q != {DW{1'b0}});

   // PID second stage and watchdog
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         pid_stage_q <= 1'b0;
         net_loss_q  <= 1'b0;
         wdog_cnt_q  <= 24'h000000;
      end else begin
         if ((pv_q > pid_hi_q) || (run_prev_q && !run_q))
            pid_stage_q <= 1'b0;
         else if (run_q && (pv_q < pid_lo_q))
            pid_stage_q <= 1'b1;
         if (comm_q || (wdog_per_q == 24'h000000)) begin
            wdog_cnt_q <= 24'h000000;
            net_loss_q <= 1'b0;
         end else if (wdog_cnt_q >= wdog_per_q - 24'h000001) begin
            net_loss_q <= 1'b1;
         end else begin
            wdog_cnt_q <= wdog_cnt_q + 24'h000001;
         end
      end
   end

   // User logic outputs
   wire [15:0] src_v = {2'b00, flags_q[`DSF_F_CAPW], 3'b000, flags_q[9:0]};
   wire [2:0]  log_res;
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_log
         dsf_logic_op u_op (
            .src_v  (src_v),
            .cfg    (lcfg_q[gi*`DSF_LCFG_W +: `DSF_LCFG_W]),
            .result (log_res[gi])
         );
      end
   endgenerate

   // Flag vector
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         flags_q      <= {NF{1'b0}};
         flags_prev_q <= {NF{1'b0}};
      end else begin
         flags_prev_q              <= flags_q;
         flags_q[`DSF_F_ZERO]      <= (ofreq_q < zero_thr_q);
         flags_q[`DSF_F_DEV]       <= (spd_err > dev_lim_q);
         flags_q[`DSF_F_POSD]      <= pos_q;
         flags_q[`DSF_F_OVF]       <= out_on && (ofreq_q >= sfreq_q);
         flags_q[`DSF_F_ATF]       <= out_on && (ofreq_q == sfreq_q);
         flags_q[`DSF_F_OVL]       <= (cur_q > ol_thr_q);
         flags_q[`DSF_F_VLOSS]     <= (ainv_q < vloss_thr_q);
         flags_q[`DSF_F_ILOSS]     <= (aini_q < iloss_thr_q);
         flags_q[`DSF_F_PIDS]      <= pid_stage_q;
         flags_q[`DSF_F_NETL]      <= net_loss_q;
         flags_q[`DSF_F_LOGC:`DSF_F_LOGA] <= log_res;
         flags_q[`DSF_F_CAPW]      <= cap_q;
      end
   end

   // Terminal outputs
   integer ti;
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         TERM_OUT <= {NTERM{1'b0}};
      end else begin
         for (ti = 0; ti < NTERM; ti = ti + 1)
            TERM_OUT[ti] <= sel_flag(tsel_q[ti*8 +: 8], flags_q);
      end
   end

   // Sticky status on rising flags; set beats clear
   always @* begin
      stat_d = stat_q;
      if (wr_fire && AVS_ADDRESS == `DSF_IRQ_STAT_OFS)
         stat_d = stat_d & ~(AVS_WRITEDATA[NF-1:0] & bmask[NF-1:0]);
      stat_d = stat_d | (flags_q & ~flags_prev_q);
   end

   // Register writes
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         zero_thr_q  <= `DSF_THR_RST;
         dev_lim_q   <= `DSF_THR_RST;
         ol_thr_q    <= `DSF_THR_RST;
         vloss_thr_q <= `DSF_THR_RST;
         iloss_thr_q <= `DSF_THR_RST;
         pid_lo_q    <= `DSF_THR_RST;
         pid_hi_q    <= `DSF_THR_RST;
         wdog_per_q  <= `DSF_WDOG_PER_RST;
         lcfg_q      <= `DSF_LOGIC_CFG_RST;
         tsel_q      <= {NTERM{8'h00}};
         mask_q      <= `DSF_MASK_RST;
         stat_q      <= {NF{1'b0}};
         IRQ         <= 1'b0;
      end else begin
         stat_q <= stat_d;
         IRQ    <= |(stat_q & mask_q);
         if (wr_fire) begin
            case (AVS_ADDRESS)
               `DSF_ZERO_THR_OFS:
                  zero_thr_q <= (zero_thr_q & wr_keep[DW-1:0]) | wr_new[DW-1:0];
               `DSF_DEV_LIM_OFS:
                  dev_lim_q <= (dev_lim_q & wr_keep[DW-1:0]) | wr_new[DW-1:0];
               `DSF_OL_THR_OFS:
                  ol_thr_q <= (ol_thr_q & wr_keep[DW-1:0]) | wr_new[DW-1:0];
               `DSF_VLOSS_THR_OFS:
                  vloss_thr_q <= (vloss_thr_q & wr_keep[DW-1:0]) | wr_new[DW-1:0];
               `DSF_ILOSS_THR_OFS:
                  iloss_thr_q <= (iloss_thr_q & wr_keep[DW-1:0]) | wr_new[DW-1:0];
               `DSF_PID_LO_OFS:
                  pid_lo_q <= (pid_lo_q & wr_keep[DW-1:0]) | wr_new[DW-1:0];
               `DSF_PID_HI_OFS:
                  pid_hi_q <= (pid_hi_q & wr_keep[DW-1:0]) | wr_new[DW-1:0];
               `DSF_WDOG_PER_OFS:
                  wdog_per_q <= (wdog_per_q & wr_keep[23:0]) | wr_new[23:0];
               `DSF_LOGIC_CFG_OFS:
                  lcfg_q <= (lcfg_q & wr_keep[29:0]) | wr_new[29:0];
               `DSF_TERM_SEL_OFS:
                  tsel_q <= (tsel_q & wr_keep[8*NTERM-1:0]) | wr_new[8*NTERM-1:0];
               `DSF_IRQ_MASK_OFS:
                  mask_q <= (mask_q & wr_keep[NF-1:0]) | wr_new[NF-1:0];
               default: begin
               end
            endcase
         end
      end
   end

   // Read mux
   reg [31:0] rd_v;
   always @* begin
      rd_v = 32'h00000000;
      case (AVS_ADDRESS)
         `DSF_ZERO_THR_OFS:  rd_v = {{(32-DW){1'b0}}, zero_thr_q};
         `DSF_DEV_LIM_OFS:   rd_v = {{(32-DW){1'b0}}, dev_lim_q};
         `DSF_OL_THR_OFS:    rd_v = {{(32-DW){1'b0}}, ol_thr_q};
         `DSF_VLOSS_THR_OFS: rd_v = {{(32-DW){1'b0}}, vloss_thr_q};
         `DSF_ILOSS_THR_OFS: rd_v = {{(32-DW){1'b0}}, iloss_thr_q};
         `DSF_PID_LO_OFS:    rd_v = {{(32-DW){1'b0}}, pid_lo_q};
         `DSF_PID_HI_OFS:    rd_v = {{(32-DW){1'b0}}, pid_hi_q};
         `DSF_WDOG_PER_OFS:  rd_v = {8'h00, wdog_per_q};
         `DSF_LOGIC_CFG_OFS: rd_v = {2'b00, lcfg_q};
         `DSF_TERM_SEL_OFS:  rd_v = {{(32-8*NTERM){1'b0}}, tsel_q};
         `DSF_FLAGS_OFS:     rd_v = {{(32-NF){1'b0}}, flags_q};
         `DSF_IRQ_STAT_OFS:  rd_v = {{(32-NF){1'b0}}, stat_q};
         `DSF_IRQ_MASK_OFS:  rd_v = {{(32-NF){1'b0}}, mask_q};
         default:            rd_v = 32'h00000000;
      endcase
   end

   // One wait state per access
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         AVS_WAITREQUEST <= 1'b1;
         AVS_READDATA    <= 32'h00000000;
      end else begin
         if (req && AVS_WAITREQUEST) begin
            AVS_WAITREQUEST <= 1'b0;
            AVS_READDATA    <= AVS_READ ? rd_v : 32'h00000000;
         end else begin
            AVS_WAITREQUEST <= 1'b1;
         end
      end
   end
endmodule

// ---- verification/dsf_flags_monitor.sv ----
`timescale 1ns/100ps
`include "dsf_map.vh"
module dsf_flags_monitor #(
   parameter NTERM = 2                            // Output terminals
) (
   input wire             CLK,                    // System clock
   input wire             RESETN,                 // Reset, active low
   input wire [7:0]       AVS_ADDRESS,            // Byte address
   input wire             AVS_READ,               // Read request
   input wire             AVS_WRITE,              // Write request
   input wire [31:0]      AVS_WRITEDATA,          // Write data
   input wire [31:0]      AVS_READDATA,           // Read data
   input wire             AVS_WAITREQUEST,        // Stall
   input wire             POS_DONE,               // Positioning complete
   input wire             CAP_EXPIRED,            // Capacitor expired
   input wire [NTERM-1:0] TERM_OUT,               // Output terminals
   input wire             IRQ                     // Interrupt
);
   reg [15:0] sel_q;
   reg [13:0] mask_q;
   wire       wr_done = AVS_WRITE && !AVS_WAITREQUEST;

   // Shadow of terminal select and mask, from completed writes
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         sel_q  <= 16'h0000;
         mask_q <= 14'h0000;
      end else if (wr_done) begin
         if (AVS_ADDRESS == `DSF_TERM_SEL_OFS)
            sel_q <= AVS_WRITEDATA[15:0];
         if (AVS_ADDRESS == `DSF_IRQ_MASK_OFS)
            mask_q <= AVS_WRITEDATA[13:0];
      end
   end

   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);

   a_wait_one_state: assert property (
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("Access not answered after one wait state");
   a_wait_low_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("Waitrequest low for more than one cycle");
   a_no_spont_ack: assert property (
      $fell(AVS_WAITREQUEST) |-> $past(AVS_READ || AVS_WRITE))
      else $error("Answer without a request");
   a_rdata_hold: assert property ($changed(AVS_READDATA) |-> !AVS_WAITREQUEST)
      else $error("Read data changed outside an answer");
   a_irq_masked: assert property (mask_q == 0 && $past(mask_q) == 0 |-> !IRQ)
      else $error("Interrupt high while fully masked");
   a_sel_zero_idle: assert property (
      sel_q == 0 && $past(sel_q) == 0 && $past(sel_q, 2) == 0 |-> TERM_OUT == 0)
      else $error("Terminal driven with no option selected");
   a_cap_term: assert property (
      (sel_q[7:0] == 8'h27 && $stable(CAP_EXPIRED)) [*5] |-> TERM_OUT[0] == CAP_EXPIRED)
      else $error("Terminal 0 does not follow capacitor warning");
   a_pos_term: assert property (
      (sel_q[15:8] == 8'h17 && $stable(POS_DONE)) [*5] |-> TERM_OUT[1] == POS_DONE)
      else $error("Terminal 1 does not follow positioning done");

   c_irq: cover property ($rose(IRQ));
   c_cap_term: cover property (TERM_OUT[0] && sel_q[7:0] == 8'h27);
   c_read: cover property (AVS_READ && !AVS_WAITREQUEST);
endmodule

bind dsf_flags dsf_flags_monitor #(.NTERM(NTERM)) i_mon (
   .CLK(CLK), .RESETN(RESETN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
   .AVS_WAITREQUEST(AVS_WAITREQUEST), .POS_DONE(POS_DONE), .CAP_EXPIRED(CAP_EXPIRED),
   .TERM_OUT(TERM_OUT), .IRQ(IRQ));

// ---- verification/dsf_relay.sv ----
`timescale 1ns/100ps
module dsf_relay #(
   parameter NTERM = 2                       // Terminals watched
) (
   input  wire             clk,              // System clock
   input  wire             rstn,             // Reset, active low
   input  wire [NTERM-1:0] term,             // Drive output terminals
   output reg  [NTERM-1:0] contact_q         // Relay contacts
);
   // Contacts pick up one cycle after the coil
   always @(posedge clk or negedge rstn) begin
      if (!rstn)
         contact_q <= {NTERM{1'b0}};
      else
         contact_q <= term;
   end
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/100ps
`include "dsf_map.vh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fails++; \
   $display("Error %s expected %h seen %h", n, e, s); end end
module tb;
   localparam [111:0] CODES = {8'h27, 8'h23, 8'h22, 8'h21, 8'h20, 8'h1f, 8'h1c,
                               8'h1b, 8'h1a, 8'h19, 8'h18, 8'h17, 8'h16, 8'h15};
   reg         clk, resetn, rd, wr, run, pos, comm, cap;
   reg  [7:0]  adr;
   reg  [31:0] wd, rq;
   reg  [15:0] ofr, sfr, scmd, sact, cur, av, ai, pv;
   reg  [13:0] e;
   wire [31:0] rdata;
   wire        wreq, irq;
   wire [1:0]  term, cont;
   integer     fails, total_checks, i;

   dsf_flags i_dut (.CLK(clk), .RESETN(resetn), .AVS_ADDRESS(adr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_BYTEENABLE(4'hf), .AVS_WRITEDATA(wd), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(wreq), .OUT_FREQ(ofr), .SET_FREQ(sfr), .SPEED_CMD(scmd),
      .SPEED_ACT(sact), .OUT_CURRENT(cur), .AIN_VOLT(av), .AIN_CURR(ai), .PID_PV(pv),
      .RUN_MODE(run), .POS_DONE(pos), .COMM_ACT(comm), .CAP_EXPIRED(cap),
      .TERM_OUT(term), .IRQ(irq));
   dsf_relay i_relay (.clk(clk), .rstn(resetn), .term(term), .contact_q(cont));

   initial begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end

   task results;
      begin
         $display("Checks %0d, errors %0d", total_checks, fails);
         if (fails == 0 && total_checks > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask

   task cyc(input integer n);
      repeat (n) @(posedge clk);
   endtask

   // Bus access, held until waitrequest is sampled low
   task acc(input w, input [7:0] a, input [31:0] d);
      integer n;
      begin
         adr <= a;
         wd <= d;
         wr <= w;
         rd <= !w;
         n = 0;
         @(posedge clk);
         while (wreq !== 1'b0 && n < 20) begin
            @(posedge clk);
            n = n + 1;
         end
         if (n == 20) begin
            fails++;
            results;
         end
         rq = rdata;
         wr <= 0;
         rd <= 0;
         @(posedge clk);
      end
   endtask

   task chkr(input [7:0] a, input [31:0] x);
      begin
         acc(0, a, 32'h0);
         `CHK("register", x, rq)
      end
   endtask

   task chkf(input [13:0] x);
      begin
         cyc(6);
         chkr(`DSF_FLAGS_OFS, {18'h0, x});
      end
   endtask

   task ping;
      begin
         comm <= 1;
         @(posedge clk);
         comm <= 0;
      end
   endtask

   initial begin
      fails = 0;
      total_checks = 0;
      {rd, wr, run, pos, comm, cap} = 6'h00;
      resetn = 0;
      adr = 8'h00;
      wd = 32'h0;
      {ofr, sfr, scmd, sact, cur} = {16'h0080, 16'h0200, 48'h0};
      {av, ai, pv} = {16'hffff, 16'hffff, 16'h0030};
      cyc(16);
      resetn <= 1;
      cyc(2);
      for (i = 0; i <= 'h34; i = i + 4)
         chkr(i[7:0], 32'h0);
      acc(1, `DSF_ZERO_THR_OFS, 32'h10);
      ofr <= 16'h0005;
      // Reset logic config ANDs bit 0 with itself
      chkf(14'h1c01);
      ofr <= 16'h0010;
      chkf(14'h0000);
      acc(1, `DSF_DEV_LIM_OFS, 32'h3);
      scmd <= 16'h000a;
      sact <= 16'h0006;
      chkf(14'h0002);
      sact <= 16'h000d;
      chkf(14'h0000);
      pos <= 1;
      chkf(14'h0004);
      pos <= 0;
      {sfr, ofr} <= {16'h0020, 16'h0020};
      chkf(14'h0018);
      ofr <= 16'h0021;
      chkf(14'h0008);
      {sfr, ofr} <= 32'h0;
      chkf(14'h1c01);
      {sfr, ofr} <= {16'h0020, 16'h0011};
      acc(1, `DSF_OL_THR_OFS, 32'h50);
      cur <= 16'h0051;
      chkf(14'h0020);
      cur <= 16'h0050;
      acc(1, `DSF_VLOSS_THR_OFS, 32'h30);
      acc(1, `DSF_ILOSS_THR_OFS, 32'h10);
      av <= 16'h002f;
      chkf(14'h0040);
      {av, ai} <= {16'h0030, 16'h000f};
      chkf(14'h0080);
      ai <= 16'h0010;
      acc(1, `DSF_PID_LO_OFS, 32'h20);
      acc(1, `DSF_PID_HI_OFS, 32'h40);
      pv <= 16'h0010;
      chkf(14'h0000);
      run <= 1;
      chkf(14'h0100);
      pv <= 16'h0030;
      chkf(14'h0100);
      pv <= 16'h0041;
      chkf(14'h0000);
      pv <= 16'h0010;
      chkf(14'h0100);
      run <= 0;
      chkf(14'h0000);
      acc(1, `DSF_WDOG_PER_OFS, 32'h14);
      repeat (6) begin
         ping;
         cyc(4);
      end
      chkf(14'h0000);
      cyc(20);
      chkf(14'h0200);
      ping;
      chkf(14'h0000);
      acc(1, `DSF_WDOG_PER_OFS, 32'h0);
      acc(1, `DSF_LOGIC_CFG_OFS, {2'h0, 10'h2d2, 10'h1d2, 10'h0d2});
      for (i = 0; i < 4; i = i + 1) begin
         {cap, pos} <= i[1:0];
         chkf({i[1], i[0] ^ i[1], i[0] | i[1], i[0] & i[1], 7'h00, i[0], 2'h0});
      end
      ofr <= 16'h0005;
      e = 14'h2c05;
      for (i = 0; i < 14; i = i + 1) begin
         acc(1, `DSF_TERM_SEL_OFS, {16'h0, CODES[i*8 +: 8], CODES[i*8 +: 8]});
         cyc(6);
         `CHK("terminals", {2{e[i]}}, term)
         `CHK("relay", {2{e[i]}}, cont)
      end
      acc(1, `DSF_TERM_SEL_OFS, 32'h171d);
      cyc(6);
      `CHK("terminals", 2'b10, term)
      acc(1, `DSF_FLAGS_OFS, 32'hffffffff);
      chkf(14'h2c05);
      acc(1, 8'h34, 32'hffffffff);
      chkr(8'h34, 32'h0);
      acc(1, `DSF_IRQ_STAT_OFS, 32'h3fff);
      chkr(`DSF_IRQ_STAT_OFS, 32'h0);
      acc(1, `DSF_IRQ_MASK_OFS, 32'h4);
      pos <= 0;
      cyc(4);
      pos <= 1;
      cyc(6);
      `CHK("irq", 1'b1, irq)
      chkr(`DSF_IRQ_STAT_OFS, 32'h1404);
      acc(1, `DSF_IRQ_MASK_OFS, 32'h0);
      cyc(2);
      `CHK("irq", 1'b0, irq)
      acc(1, `DSF_IRQ_MASK_OFS, 32'h4);
      cyc(2);
      `CHK("irq", 1'b1, irq)
      acc(1, `DSF_IRQ_STAT_OFS, 32'h4);
      cyc(2);
      `CHK("irq", 1'b0, irq)
      chkr(`DSF_IRQ_STAT_OFS, 32'h1400);
      resetn <= 0;
      cyc(2);
      `CHK("terminals", 2'b00, term)
      resetn <= 1;
      cyc(2);
      chkr(`DSF_TERM_SEL_OFS, 32'h0);
      results;
   end
endmodule
